// *** common/iexp_defines.vh ***
// Constants for the I2C port expander slave: codes, addresses, reset values
`ifndef IEXP_DEFINES_VH
`define IEXP_DEFINES_VH
`define IEXP_GCALL_ADDR 8'h00
`define IEXP_RESET_CODE 8'h06
`define IEXP_ID_ADDR7 7'h7c
`define IEXP_PORT_RESET 8'hff
`define IEXP_MFR_ID 12'h5a5
`define IEXP_PART_ID 9'h0c3
`define IEXP_REV_ID 3'h1
`define IEXP_ID_BYTES 2'h3
`endif

// *** rtl/iexp_slave.v ***
// I2C slave of the quasi-bidirectional 8-bit port expander
// Notes on behaviour
// - Ack general call only as 00h write
// - Ack following byte only if 06h
// - No ack for further general call bytes
// - Reset code plus STOP restores power-up state
// - Repeated START after code: no reset
// - Declined reset bytes leave registers untouched
// - Hardwired 24-bit identity: 12/9/3 fields
// - Ack identity target byte if own address
// - STOP or foreign address abandons identity read
// - Identity shifted MSB first, manufacturer first
// - Master nack ends identity read, ignore until START/STOP
// - Stop sending identity on master nack
// - Keep acking: wrap to first identity byte
// - Port read returns live pin levels
// - Single port register, no command byte
// - One byte covers all eight pins
// - Pins released high at power-on
// - Strong pull-up only during ack high
// - Written zero holds strong sink low
// - Unlimited write bytes, each overwrites port
`timescale 1ns/10ps
`default_nettype none
`include "iexp_defines.vh"
module iexp_slave #(
    parameter [6:0] OWN_ADDR = 7'h20, // Own slave address
    parameter [11:0] MFR_ID = `IEXP_MFR_ID, // Arbitrary value
    parameter [8:0] PART_ID = `IEXP_PART_ID, // Arbitrary value
    parameter [2:0] REV_ID = `IEXP_REV_ID // Arbitrary value
) (
    input wire i_clk,
    input wire i_reset_n,
    input wire i_scl,
    input wire i_sda,
    output reg o_sda_oe_n,
    input wire [7:0] i_pin,
    output reg [7:0] o_sink,
    output reg [7:0] o_boost
);
    // ****************************************
    // States and signals
    // ****************************************
    localparam ST_IDLE = 3'd0; // Waiting for address
    localparam ST_RX = 3'd1; // Receiving a byte
    localparam ST_ACK = 3'd2; // Ack slot
    localparam ST_TX = 3'd3; // Sending a byte
    localparam ST_MACK = 3'd4; // Master ack slot
    localparam ST_IGN = 3'd5; // Ignore until START/STOP
    localparam PH_ADDR = 3'd0; // Address byte
    localparam PH_PWR = 3'd1; // Port write data
    localparam PH_GC = 3'd2; // General call data
    localparam PH_GCX = 3'd3; // Extra general call data
    localparam PH_IDT = 3'd4; // Identity target byte
    localparam PH_PRD = 3'd5; // Port read
    localparam PH_IRD = 3'd6; // Identity read
    wire scl_q, sda_q, scl_rise, scl_fall, start_c, stop_c;
    reg [2:0] st_q; // Main state
    reg [2:0] ph_q; // Transfer phase
    reg [2:0] bit_q; // Bit counter
    reg [7:0] sh_q; // Shift register
    reg ack_q; // Ack decided for this slot
    reg [7:0] port_q; // Port latch
    reg id_armed_q; // Identity target acked
    reg rst_armed_q; // Reset code acked
    reg [1:0] id_idx_q; // Identity byte index
    reg soft_rst; // Software reset request
    reg byte_q; // Eight bits shifted in, byte ends at next fall
    reg wr_ack_q; // Ack slot belongs to a port data byte
    wire [23:0] id_word = {MFR_ID, PART_ID, REV_ID};
    // Select an identity byte, manufacturer first
    function [7:0] id_byte;
        input [1:0] idx;
        begin
            case (idx)
                2'd0: id_byte = id_word[23:16];
                2'd1: id_byte = id_word[15:8];
                default: id_byte = id_word[7:0];
            endcase
        end
    endfunction
    // Identity byte at the current index, MSB goes out first
    wire [7:0] id_cur = id_byte(id_idx_q);
    // ****************************************
    // Line sampler
    // ****************************************
    iexp_sync_edge u_sync (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_scl(i_scl),
        .i_sda(i_sda),
        .o_scl_q(scl_q),
        .o_sda_q(sda_q),
        .o_scl_rise(scl_rise),
        .o_scl_fall(scl_fall),
        .o_start(start_c),
        .o_stop(stop_c)
    );
    // Reset fires on STOP after acked code
    always @* begin
        soft_rst = stop_c & rst_armed_q;
    end
    // ****************************************
    // Protocol engine
    // ****************************************
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_q <= ST_IDLE;
            ph_q <= PH_ADDR;
            bit_q <= 3'd0;
            sh_q <= 8'h00;
            ack_q <= 1'b0;
            port_q <= `IEXP_PORT_RESET;
            id_armed_q <= 1'b0;
            rst_armed_q <= 1'b0;
            id_idx_q <= 2'd0;
            o_sda_oe_n <= 1'b1;
            byte_q <= 1'b0;
            wr_ack_q <= 1'b0;
        end else if (soft_rst) begin
            // Back to power-up values
            st_q <= ST_IDLE;
            ph_q <= PH_ADDR;
            bit_q <= 3'd0;
            sh_q <= 8'h00;
            ack_q <= 1'b0;
            port_q <= `IEXP_PORT_RESET;
            id_armed_q <= 1'b0;
            rst_armed_q <= 1'b0;
            id_idx_q <= 2'd0;
            o_sda_oe_n <= 1'b1;
            byte_q <= 1'b0;
            wr_ack_q <= 1'b0;
        end else if (stop_c) begin
            // STOP drops any pending identity read
            st_q <= ST_IDLE;
            ph_q <= PH_ADDR;
            id_armed_q <= 1'b0;
            o_sda_oe_n <= 1'b1;
        end else if (start_c) begin
            // Repeated START cancels pending reset
            st_q <= ST_RX;
            ph_q <= PH_ADDR;
            bit_q <= 3'd0;
            byte_q <= 1'b0; // SCL fall after START is no byte end
            rst_armed_q <= 1'b0;
            o_sda_oe_n <= 1'b1;
        end else begin
            case (st_q)
                ST_RX: begin
                    if (scl_rise) begin
                        sh_q <= {sh_q[6:0], sda_q};
                        bit_q <= bit_q + 3'd1;
                        // Eighth bit in: byte ends at next fall
                        if (bit_q == 3'd7) begin
                            byte_q <= 1'b1;
                        end
                    end else if (scl_fall && byte_q) begin
                        // Full byte received: decide ack
                        st_q <= ST_ACK;
                        byte_q <= 1'b0;
                        ack_q <= 1'b0;
                        wr_ack_q <= 1'b0;
                        case (ph_q)
                            PH_ADDR: begin
                                if (sh_q == `IEXP_GCALL_ADDR) begin
                                    ack_q <= 1'b1;
                                    ph_q <= PH_GC;
                                end else if (sh_q[7:1] == `IEXP_ID_ADDR7
                                    && !sh_q[0]) begin
                                    ack_q <= 1'b1;
                                    ph_q <= PH_IDT;
                                    id_armed_q <= 1'b0;
                                end else if (sh_q[7:1] == `IEXP_ID_ADDR7
                                    && id_armed_q) begin
                                    ack_q <= 1'b1;
                                    ph_q <= PH_IRD;
                                    id_idx_q <= 2'd0;
                                end else if (sh_q[7:1] == OWN_ADDR) begin
                                    ack_q <= 1'b1;
                                    ph_q <= sh_q[0] ? PH_PRD : PH_PWR;
                                    id_armed_q <= 1'b0;
                                end else begin
                                    // Foreign slave: drop identity
                                    id_armed_q <= 1'b0;
                                    st_q <= ST_IGN;
                                end
                            end
                            PH_GC: begin
                                if (sh_q == `IEXP_RESET_CODE) begin
                                    ack_q <= 1'b1;
                                    rst_armed_q <= 1'b1;
                                    ph_q <= PH_GCX;
                                end else begin
                                    st_q <= ST_IGN;
                                end
                            end
                            PH_GCX: begin
                                // No more acks, no reset either
                                rst_armed_q <= 1'b0;
                                st_q <= ST_IGN;
                            end
                            PH_IDT: begin
                                if (sh_q[7:1] == OWN_ADDR) begin
                                    ack_q <= 1'b1;
                                    id_armed_q <= 1'b1;
                                end else begin
                                    st_q <= ST_IGN;
                                end
                            end
                            default: begin
                                // Port write: every byte taken
                                ack_q <= 1'b1;
                                wr_ack_q <= 1'b1;
                                port_q <= sh_q;
                            end
                        endcase
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        // Ack slot over
                        o_sda_oe_n <= 1'b1;
                        bit_q <= 3'd0;
                        if (!ack_q) begin
                            st_q <= ST_IGN;
                        end else if (ph_q == PH_PRD) begin
                            st_q <= ST_TX;
                            sh_q <= i_pin;
                            o_sda_oe_n <= i_pin[7];
                        end else if (ph_q == PH_IRD) begin
                            st_q <= ST_TX;
                            sh_q <= id_cur;
                            o_sda_oe_n <= id_cur[7];
                        end else begin
                            st_q <= ST_RX;
                        end
                    end else begin
                        // Pull SDA through the whole ack clock
                        o_sda_oe_n <= ~ack_q;
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        bit_q <= bit_q + 3'd1;
                        if (bit_q == 3'd7) begin
                            o_sda_oe_n <= 1'b1; // Release for master
                            st_q <= ST_MACK;
                        end else begin
                            sh_q <= {sh_q[6:0], 1'b0};
                            o_sda_oe_n <= sh_q[6];
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise) begin
                        if (sda_q) begin
                            // Master nack: stop sending
                            st_q <= ST_IGN;
                            id_armed_q <= 1'b0;
                        end else if (ph_q == PH_IRD) begin
                            if (id_idx_q == `IEXP_ID_BYTES - 2'd1) begin
                                id_idx_q <= 2'd0;
                            end else begin
                                id_idx_q <= id_idx_q + 2'd1;
                            end
                        end
                    end else if (scl_fall) begin
                        // Next byte goes out
                        st_q <= ST_TX;
                        bit_q <= 3'd0;
                        sh_q <= ph_q == PH_PRD ? i_pin : id_cur;
                        o_sda_oe_n <= ph_q == PH_PRD ? i_pin[7] : id_cur[7];
                    end
                end
                ST_IGN: begin
                    o_sda_oe_n <= 1'b1; // Wait for START or STOP
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end
    // ****************************************
    // Pin drivers
    // ****************************************
    // Sink follows zeros; boost only while ack SCL high
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_sink <= 8'h00;
            o_boost <= 8'h00;
        end else begin
            o_sink <= ~port_q;
            // Address ack never boosts, only a port data byte ack
            o_boost <= (st_q == ST_ACK && wr_ack_q && !o_sda_oe_n
                && scl_q) ? port_q : 8'h00;
        end
    end
endmodule // iexp_slave
`default_nettype wire

// *** rtl/iexp_sync_edge.v ***
// Bus line sampler: registered copies of SCL and SDA with edge flags
`timescale 1ns/10ps
`default_nettype none
module iexp_sync_edge (
    input wire i_clk,
    input wire i_reset_n,
    input wire i_scl,
    input wire i_sda,
    output reg o_scl_q,
    output reg o_sda_q,
    output wire o_scl_rise,
    output wire o_scl_fall,
    output wire o_start,
    output wire o_stop
);
    // ****************************************
    // Line history
    // ****************************************
    reg scl_p_q; // Previous SCL
    reg sda_p_q; // Previous SDA
    // Sample lines every clock
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_scl_q <= 1'b1;
            o_sda_q <= 1'b1;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            o_scl_q <= i_scl;
            o_sda_q <= i_sda;
            scl_p_q <= o_scl_q;
            sda_p_q <= o_sda_q;
        end
    end
    assign o_scl_rise = o_scl_q & ~scl_p_q;
    assign o_scl_fall = ~o_scl_q & scl_p_q;
    // SDA falls while SCL high
    assign o_start = o_scl_q & scl_p_q & sda_p_q & ~o_sda_q;
    // SDA rises while SCL high
    assign o_stop = o_scl_q & scl_p_q & ~sda_p_q & o_sda_q;
endmodule // iexp_sync_edge
`default_nettype wire

// *** tb/iexp_i2c_master.sv ***
// Behavioural I2C bus master driving the expander
`timescale 1ns/10ps
`default_nettype none
module iexp_i2c_master #(
    parameter int HP = 16 // Clocks per SCL half period
) (
    input wire logic i_clk,
    input wire logic i_sda_oe_n,
    output logic o_scl,
    output logic o_sda
);
    logic sda_m = 1'b1; // Own SDA drive, 1 = released
    logic [7:0] rval; // Last byte or ack bit seen
    event got; // Fires on a fresh rval
    initial o_scl = 1'b1;
    // Open-drain line with pull-up
    assign o_sda = sda_m & i_sda_oe_n;
    task automatic hp();
        repeat (HP) @(negedge i_clk);
    endtask
    // Start or repeated start: SDA falls with SCL high
    task automatic start();
        sda_m = 1'b1;
        hp();
        o_scl = 1'b1;
        hp();
        sda_m = 1'b0;
        hp();
        o_scl = 1'b0;
        hp();
    endtask
    // Stop: SDA rises with SCL high
    task automatic stop();
        sda_m = 1'b0;
        hp();
        o_scl = 1'b1;
        hp();
        sda_m = 1'b1;
        hp();
    endtask
    // One bit, sampled late in SCL high, held past the fall
    task automatic bit_io(input logic b, output logic r);
        sda_m = b;
        hp();
        o_scl = 1'b1;
        hp();
        r = o_sda;
        o_scl = 1'b0;
        repeat (4) @(negedge i_clk);
    endtask
    task automatic xfer(input logic [7:0] d, output logic [7:0] r);
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r[i]);
    endtask
    // Send a byte, report the ack bit seen
    task automatic wbyte(input logic [7:0] d);
        logic [7:0] r;
        logic a;
        xfer(d, r);
        bit_io(1'b1, a);
        rval = {7'h00, a};
        -> got;
    endtask
    // Receive a byte, then ack or nack it
    task automatic rbyte(input logic nak);
        logic [7:0] r;
        logic a;
        xfer(8'hff, r);
        rval = r;
        -> got;
        bit_io(nak, a);
    endtask
endmodule // iexp_i2c_master
`default_nettype wire

// *** tb/iexp_slave_properties.sv ***
// Assertion checker for the I2C port expander slave
`timescale 1ns/10ps
`default_nettype none
module iexp_slave_chk (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic o_sda_oe_n,
    input wire logic [7:0] i_pin,
    input wire logic [7:0] o_sink,
    input wire logic [7:0] o_boost
);
    // One domain, reset switches every check off
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    // ****************************************
    // Bus and pin properties
    // ****************************************
    reset_state_a: assert property ($rose(i_reset_n) |-> o_sda_oe_n &&
        o_sink == 8'h00 && o_boost == 8'h00) else $error("not idle at reset");
    boost_rise_a: assert property ($rose(|o_boost) |-> $past(i_scl) &&
        !o_sda_oe_n) else $error("boost outside ack high");
    boost_width_a: assert property ($rose(|o_boost) |=> (|o_boost) [*4])
        else $error("boost pulse too short");
    boost_drop_a: assert property ($fell(i_scl) |-> ##[1:4] o_boost == 8'h00)
        else $error("boost kept after clock fall");
    sink_boost_a: assert property ((o_boost & o_sink) == 8'h00)
        else $error("sink and boost on one pin");
    sink_ack_a: assert property ($changed(o_sink) && o_sink != 8'h00 |->
        !o_sda_oe_n) else $error("sink set outside ack");
    ack_hold_a: assert property ($fell(o_sda_oe_n) |-> !o_sda_oe_n [*8])
        else $error("sda pull too short");
    sda_low_a: assert property ($changed(o_sda_oe_n) |-> !$past(i_scl))
        else $error("sda moved while clock high");
    // Main scenarios reached
    cover property (o_sink != 8'h00);
    cover property ($rose(|o_boost));
    cover property ($fell(|o_sink));
endmodule // iexp_slave_chk
bind iexp_slave iexp_slave_chk u_chk (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_scl(i_scl), .i_sda(i_sda), .o_sda_oe_n(o_sda_oe_n), .i_pin(i_pin),
    .o_sink(o_sink), .o_boost(o_boost));
`default_nettype wire

// *** tb/iexp_slave_tb.sv ***
// Self-checking testbench of the I2C port expander slave
`timescale 1ns/10ps
`default_nettype none
`include "iexp_defines.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module iexp_slave_tb;
    localparam [23:0] ID = {`IEXP_MFR_ID, `IEXP_PART_ID, `IEXP_REV_ID};
    logic i_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic scl, sda, oe_n;
    logic [7:0] ext = 8'hff; // External level on each pin
    logic [7:0] sink, boost, pin, d;
    logic [31:0] lfsr_q = 32'h614d;
    logic [7:0] exp_q[$]; // Expected results, oldest first
    logic [7:0] exp_v; // Oldest expected result
    logic [7:0] boost_last = 8'h00; // Last strong pull-up pulse seen
    int num_errors = 0;
    int compares = 0;
    always #4 i_clk = ~i_clk;
    // Strong sink wins over the external level
    assign pin = ext & ~sink;
    iexp_i2c_master u_mst (.i_clk(i_clk), .i_sda_oe_n(oe_n), .o_scl(scl),
        .o_sda(sda));
    iexp_slave u_dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_scl(scl),
        .i_sda(sda), .o_sda_oe_n(oe_n), .i_pin(pin), .o_sink(sink),
        .o_boost(boost));
    function automatic [31:0] lfsr_next(input [31:0] s);
        lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Note the expected ack, then send
    task automatic wr(input logic [7:0] v, input logic nak);
        exp_q.push_back({7'h00, nak});
        u_mst.wbyte(v);
    endtask
    // Note the expected byte, then read
    task automatic rd(input logic [7:0] v, input logic nak);
        exp_q.push_back(v);
        u_mst.rbyte(nak);
    endtask
    // General call then one code byte
    task automatic gc(input logic [7:0] v, input logic nak);
        u_mst.start();
        wr(8'h00, 1'b0);
        wr(v, nak);
    endtask
    // Identity address then target byte
    task automatic id_arm(input logic [7:0] t, input logic nak);
        u_mst.start();
        wr(8'hf8, 1'b0);
        wr(t, nak);
    endtask
    task automatic finish_test();
        $display("compares=%0d num_errors=%0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Result watcher
    always @(u_mst.got) begin
        exp_v = exp_q.pop_front();
        `CHK(u_mst.rval, exp_v)
    end
    // Keep the last strong pull-up pulse
    always @(posedge i_clk) begin
        if (|boost) begin
            boost_last <= boost;
        end
    end
    // Hang guard
    initial begin
        repeat (60000) @(posedge i_clk);
        num_errors++;
        finish_test();
    end
    // Main sequence
    initial begin
        repeat (20) @(negedge i_clk);
        i_reset_n = 1'b1;
        lfsr_q = lfsr_next(lfsr_q);
        ext = lfsr_q[7:0];
        d = lfsr_q[15:8] & 8'h7f;
        u_mst.start();
        wr(8'h41, 1'b0);
        rd(ext, 1'b1);
        u_mst.stop();
        u_mst.start();
        wr(8'h40, 1'b0);
        wr(~d, 1'b0);
        wr(d, 1'b0);
        u_mst.stop();
        `CHK(sink, ~d)
        `CHK(boost_last, d)
        u_mst.start();
        wr(8'h41, 1'b0);
        rd(ext & d, 1'b0);
        rd(ext & d, 1'b1);
        u_mst.stop();
        u_mst.start();
        wr(8'h01, 1'b1);
        u_mst.stop();
        gc(8'h07, 1'b1);
        u_mst.stop();
        gc(8'h06, 1'b0);
        wr(8'h06, 1'b1);
        u_mst.stop();
        gc(8'h06, 1'b0);
        u_mst.start();
        u_mst.stop();
        `CHK(sink, ~d)
        gc(8'h06, 1'b0);
        u_mst.stop();
        `CHK(sink, 8'h00)
        id_arm(8'h41, 1'b0);
        u_mst.start();
        wr(8'hf9, 1'b0);
        for (int k = 0; k < 5; k++)
            rd(ID[23 - 8 * (k % 3) -: 8], k == 4);
        u_mst.stop();
        id_arm(8'h42, 1'b1);
        u_mst.stop();
        id_arm(8'h40, 1'b0);
        u_mst.stop();
        u_mst.start();
        wr(8'hf9, 1'b1);
        u_mst.stop();
        id_arm(8'h40, 1'b0);
        u_mst.start();
        wr(8'hf9, 1'b0);
        rd(ID[23:16], 1'b1);
        u_mst.stop();
        u_mst.start();
        wr(8'h41, 1'b0);
        rd(ext, 1'b1);
        u_mst.stop();
        finish_test();
    end
endmodule // iexp_slave_tb
`default_nettype wire
